// [ebp_defs.svh]
/*
 * Offsets, field positions, reset values and widths of the eight-bit I/O port.
 * Assumes it is included by bare name before the package and the port module.
 */
`ifndef EBP_DEFS_SVH
`define EBP_DEFS_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define EBP_IDX_PIN_DATA 8'h07
`define EBP_IDX_DIRECTION 8'h87
`define EBP_IDX_BIT_SET 8'h10
`define EBP_IDX_BIT_CLEAR 8'h11

// ************************************************************
// widths and reset values
// ************************************************************
`define EBP_PORT_W 8
`define EBP_ADDR_W 10
`define EBP_DATA_W 32
`define EBP_DIR_RESET 8'hff
`define EBP_LATCH_POR 8'h00
`define EBP_LANE0 0

`endif

// [ebp_io_port.sv]
/*
 * Eight-bit bidirectional I/O port with per-bit direction, reached over an
 * Avalon-MM slave with waitrequest. Assumes pin inputs synchronous to sys_clk,
 * and a board-level tri-state buffer built from pin_out and pin_oe.
 */
`default_nettype none

`include "ebp_defs.svh"

module ebp_io_port #(
    parameter int PORT_W = `EBP_PORT_W
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic other_reset,
    input wire logic [`EBP_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [`EBP_DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [`EBP_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [PORT_W-1:0] pin_in,
    output logic [PORT_W-1:0] pin_out,
    output logic [PORT_W-1:0] pin_oe
);
    import ebp_pkg::*;

    // ************************************************************
    // elaboration checks
    // ************************************************************
    // the port sits in byte lane 0 of the bus word
    if (PORT_W < 1 || PORT_W > `EBP_PORT_W) begin : g_bad_width
        $error("port width must be 1 to 8");
    end

    localparam logic [`EBP_PORT_W-1:0] DIR_RST8 = `EBP_DIR_RESET;
    localparam logic [`EBP_PORT_W-1:0] POR8 = `EBP_LATCH_POR;
    localparam logic [PORT_W-1:0] DIR_RST = DIR_RST8[PORT_W-1:0];
    localparam logic [PORT_W-1:0] LATCH_POR = POR8[PORT_W-1:0];
    localparam logic [`EBP_ADDR_W-1:0] A_DATA = {`EBP_IDX_PIN_DATA, 2'b00};
    localparam logic [`EBP_ADDR_W-1:0] A_DIR = {`EBP_IDX_DIRECTION, 2'b00};
    localparam logic [`EBP_ADDR_W-1:0] A_SET = {`EBP_IDX_BIT_SET, 2'b00};
    localparam logic [`EBP_ADDR_W-1:0] A_CLR = {`EBP_IDX_BIT_CLEAR, 2'b00};

    function automatic ebp_sel_e decode(input logic [`EBP_ADDR_W-1:0] a);
        ebp_sel_e s;
        case (a)
            A_DATA: s = EBP_SEL_DATA;
            A_DIR: s = EBP_SEL_DIR;
            A_SET: s = EBP_SEL_SET;
            A_CLR: s = EBP_SEL_CLEAR;
            default: s = EBP_SEL_NONE;
        endcase
        return s;
    endfunction

    // ************************************************************
    // bus access controller
    // ************************************************************
    ebp_state_e st_q, st_d;
    ebp_req_s req_q, req_d;
    logic [PORT_W-1:0] smp_q, smp_d;
    logic [PORT_W-1:0] rdata_q, rdata_d;
    logic [PORT_W-1:0] latch_q, latch_d;
    logic [PORT_W-1:0] dir_q, dir_d;
    ebp_sel_e sel_now;
    logic [PORT_W-1:0] wd;

    assign sel_now = decode(avs_address);

    always_comb begin
        st_d = st_q;
        req_d = req_q;
        smp_d = smp_q;
        rdata_d = rdata_q;
        case (st_q)
            EBP_IDLE: begin
                if (avs_read || avs_write) begin
                    st_d = EBP_ACK;
                    req_d.sel = sel_now;
                    req_d.we = avs_write;
                    req_d.be0 = avs_byteenable[`EBP_LANE0];
                    req_d.wdata = avs_writedata[`EBP_PORT_W-1:0];
                    // pins caught at the start of the access
                    smp_d = pin_in;
                    if (avs_read && sel_now == EBP_SEL_DATA) begin
                        rdata_d = pin_in;
                    end else if (avs_read && sel_now == EBP_SEL_DIR) begin
                        rdata_d = dir_q;
                    end else begin
                        rdata_d = '0;
                    end
                end
            end
            EBP_ACK: begin
                st_d = EBP_IDLE;
            end
            default: begin
                st_d = EBP_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= EBP_IDLE;
            req_q <= EBP_REQ_IDLE;
            smp_q <= '0;
            rdata_q <= '0;
        end else begin
            st_q <= st_d;
            req_q <= req_d;
            smp_q <= smp_d;
            rdata_q <= rdata_d;
        end
    end

    // ************************************************************
    // output latch and direction
    // ************************************************************
    // set, clear and lane-off data writes build the latch from sampled pins, never from its old value, so an
    // input bit picks up whatever level the board shows at the time
    assign wd = req_q.wdata[PORT_W-1:0];

    always_comb begin
        latch_d = latch_q;
        dir_d = dir_q;
        if (st_q == EBP_ACK && req_q.we) begin
            case (req_q.sel)
                EBP_SEL_DATA: begin
                    latch_d = req_q.be0 ? wd : smp_q;
                end
                EBP_SEL_SET: begin
                    latch_d = req_q.be0 ? (smp_q | wd) : smp_q;
                end
                EBP_SEL_CLEAR: begin
                    latch_d = req_q.be0 ? (smp_q & ~wd) : smp_q;
                end
                EBP_SEL_DIR: begin
                    if (req_q.be0) begin
                        dir_d = wd;
                    end
                end
                default: begin
                    latch_d = latch_q;
                end
            endcase
        end
        // warm reset wins over a direction write; latch left alone
        if (other_reset) begin
            dir_d = DIR_RST;
        end
    end

    // no real unknown at power-on: a fixed pattern stands in for it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_q <= LATCH_POR;
            dir_q <= DIR_RST;
        end else begin
            latch_q <= latch_d;
            dir_q <= dir_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign pin_oe = ~dir_q;
    assign pin_out = latch_q;
    assign avs_readdata = `EBP_DATA_W'(rdata_q);
    assign avs_waitrequest = (st_q != EBP_ACK);

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_input_no_drive: assert property (
        (dir_q == DIR_RST) |-> (pin_oe == '0)
    ) else $error("input pin still driven");

    a_output_drives_latch: assert property (
        (st_q == EBP_IDLE && avs_write && sel_now == EBP_SEL_DATA
            && avs_byteenable[`EBP_LANE0])
        |-> ##2 (pin_out == $past(avs_writedata[PORT_W-1:0], 2))
    ) else $error("pin output not the written latch");

    a_read_is_pins: assert property (
        (st_q == EBP_IDLE && avs_read && sel_now == EBP_SEL_DATA && !other_reset)
        |=> (!avs_waitrequest && avs_readdata[PORT_W-1:0] == $past(pin_in))
    ) else $error("data read did not return pins");

    a_set_rmw: assert property (
        (st_q == EBP_IDLE && avs_write && sel_now == EBP_SEL_SET
            && avs_byteenable[`EBP_LANE0])
        |-> ##2 (latch_q == ($past(pin_in, 2) | $past(avs_writedata[PORT_W-1:0], 2)))
    ) else $error("bit set not built from pins");

    a_input_overwrite: assert property (
        (st_q == EBP_IDLE && avs_write && sel_now == EBP_SEL_DATA
            && !avs_byteenable[`EBP_LANE0])
        |-> ##2 (latch_q == $past(pin_in, 2))
    ) else $error("latch not refreshed from pins");

    a_warm_reset_dir: assert property (
        other_reset |=> (dir_q == DIR_RST && pin_oe == '0)
    ) else $error("warm reset left an output");

    a_warm_keeps_latch: assert property (
        (other_reset && st_q == EBP_IDLE) |=> $stable(latch_q)
    ) else $error("warm reset disturbed latch");

    a_dir_per_bit: assert property (
        (st_q == EBP_IDLE && avs_write && sel_now == EBP_SEL_DIR
            && avs_byteenable[`EBP_LANE0] && !other_reset) ##1 !other_reset
        |=> (pin_oe == ~$past(avs_writedata[PORT_W-1:0], 2))
    ) else $error("direction bits not applied per bit");

    a_write_at_end: assert property (
        (st_q == EBP_IDLE && avs_write) |=> ($stable(latch_q) && !avs_waitrequest)
    ) else $error("latch changed before end of access");

    a_read_at_start: assert property (
        (st_q == EBP_IDLE && avs_read && sel_now == EBP_SEL_DATA)
        |=> (rdata_q == $past(pin_in)) ##1 avs_waitrequest
    ) else $error("read not sampled at access start");

    // ************************************************************
    // pin and access-order checks
    // ************************************************************
    // pins move only at the end of an access or on a warm reset, so each change has one cause

    a_clear_rmw: assert property (
        (st_q == EBP_IDLE && avs_write && sel_now == EBP_SEL_CLEAR
            && avs_byteenable[`EBP_LANE0])
        |-> ##2 (latch_q == ($past(pin_in, 2) & ~$past(avs_writedata[PORT_W-1:0], 2)))
    ) else $error("bit clear not built from pins");

    a_set_clear_pins: assert property (
        (st_q == EBP_IDLE && avs_write && !avs_byteenable[`EBP_LANE0]
            && (sel_now == EBP_SEL_SET || sel_now == EBP_SEL_CLEAR))
        |-> ##2 (latch_q == $past(pin_in, 2))
    ) else $error("lane-off bit write not taken from pins");

    a_dir_lane_off: assert property (
        (st_q == EBP_IDLE && avs_write && sel_now == EBP_SEL_DIR
            && !avs_byteenable[`EBP_LANE0] && !other_reset) ##1 !other_reset
        |=> (pin_oe == $past(pin_oe, 2))
    ) else $error("direction changed with lane off");

    a_dir_readback: assert property (
        (st_q == EBP_IDLE && avs_read && sel_now == EBP_SEL_DIR)
        |=> (!avs_waitrequest && avs_readdata[PORT_W-1:0] == ~$past(pin_oe))
    ) else $error("direction read does not match drivers");

    a_answer_once: assert property (
        (st_q == EBP_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest ##1 avs_waitrequest
    ) else $error("access not answered in exactly one cycle");

    a_oe_dir_only: assert property (
        $changed(pin_oe)
        |-> ($past(other_reset)
            || $past(st_q == EBP_ACK && req_q.we && req_q.sel == EBP_SEL_DIR))
    ) else $error("pin drivers changed without a direction write");

    a_out_write_only: assert property (
        $changed(pin_out) |-> $past(st_q == EBP_ACK && req_q.we)
    ) else $error("pin output changed outside a write");

    a_read_no_effect: assert property (
        (st_q == EBP_IDLE && avs_read && !other_reset) ##1 !other_reset
        |=> ($stable(latch_q) && $stable(pin_oe))
    ) else $error("read disturbed latch or drivers");

    a_data_keeps_dir: assert property (
        (st_q == EBP_IDLE && avs_write && sel_now != EBP_SEL_DIR && !other_reset)
        ##1 !other_reset |=> $stable(pin_oe)
    ) else $error("latch write disturbed direction");

endmodule

`default_nettype wire

// [ebp_io_port_tb.sv]
/*
 * Self-checking bench for the eight-bit I/O port, with a reference model.
 * Assumes the port package, defines header and pin model are compiled first.
 */
`default_nettype none

`include "ebp_defs.svh"

module ebp_io_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ebp_pkg::*;
    logic sys_clk, rst_n, other_reset, avs_read, avs_write, avs_waitrequest;
    logic [9:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [7:0] pin_in, pin_out, pin_oe, ext_drive, latch_m, dir_m;
    int error_cnt = 0;
    int n_tests = 0;
    ebp_io_port dut (.sys_clk(sys_clk), .rst_n(rst_n), .other_reset(other_reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    ebp_pin_model board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_drive(ext_drive),
        .pin_in(pin_in));
    // ************************************************************
    // checking and bus tasks
    // ************************************************************
    task automatic final_report;
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // caller is just past a rising edge; no cycle count is assumed
    task automatic access(input logic [9:0] a, input logic wr, input logic [7:0] d,
                          input logic be, output logic [31:0] rd);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= {3'h0, be};
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        chk({31'h0, avs_waitrequest}, 32'h0);
    endtask
    // kinds: 0 data wr, 1 dir wr, 2 set, 3 clear, 4 data rd, 5 dir rd, 6/7 unmapped
    task automatic op(input int k, input logic [7:0] d, input logic be);
        logic [7:0] pins;
        logic [31:0] rd;
        logic [9:0] a;
        @(posedge sys_clk);
        pins = (latch_m & ~dir_m) | (ext_drive & dir_m);
        case (k)
            0, 4: a = 10'h01c;
            1, 5: a = 10'h21c;
            2: a = 10'h040;
            3: a = 10'h044;
            default: a = 10'h3fc;
        endcase
        access(a, k < 4 || k == 6, d, be, rd);
        case (k)
            0: latch_m = be ? d : pins;
            1: dir_m = be ? d : dir_m;
            2: latch_m = pins | (be ? d : 8'h00);
            3: latch_m = pins & ~(be ? d : 8'h00);
            4: chk(rd, {24'h0, pins});
            5: chk(rd, {24'h0, dir_m});
            7: chk(rd, 32'h0);
            default: ;
        endcase
        #1;
        chk({24'h0, pin_oe}, {24'h0, ~dir_m});
        chk({24'h0, pin_out}, {24'h0, latch_m});
    endtask
    // ************************************************************
    // clock, stimulus, watchdog
    // ************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        #20000;
        error_cnt++;
        final_report();
    end
    initial begin
        rst_n = 1'b0;
        other_reset = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = '0;
        ext_drive = 8'h5a;
        latch_m = `EBP_LATCH_POR;
        dir_m = `EBP_DIR_RESET;
        void'($urandom(8));
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        chk({24'h0, pin_oe}, 32'h0);
        chk({24'h0, pin_out}, {24'h0, `EBP_LATCH_POR});
        op(5, 8'h00, 1'b0);
        op(1, 8'h0f, 1'b1);
        op(0, 8'ha5, 1'b1);
        op(4, 8'h00, 1'b0);
        op(0, 8'h3c, 1'b0);
        op(2, 8'hc0, 1'b1);
        op(3, 8'h03, 1'b1);
        op(1, 8'hff, 1'b0);
        op(6, 8'h55, 1'b1);
        op(7, 8'h00, 1'b0);
        $display("test directed done");
        op(1, 8'h00, 1'b1);
        @(posedge sys_clk);
        other_reset <= 1'b1;
        @(posedge sys_clk);
        other_reset <= 1'b0;
        dir_m = 8'hff;
        #1;
        chk({24'h0, pin_oe}, 32'h0);
        chk({24'h0, pin_out}, {24'h0, latch_m});
        op(5, 8'h00, 1'b0);
        $display("test warm reset done");
        repeat (80) begin
            @(posedge sys_clk);
            ext_drive <= 8'($urandom);
            op(int'($urandom_range(7, 0)), 8'($urandom), 1'($urandom));
        end
        $display("test random done");
        final_report();
    end
endmodule

`default_nettype wire

// [ebp_pin_model.sv]
/*
 * Board model for the eight-bit port pins: outside drivers on input bits.
 * Assumes pin_oe high means the port drives that pin.
 */
`default_nettype none

module ebp_pin_model (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_drive,
    output logic [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // pin levels
    // ************************************************************
    // board backs off where the port drives, no wired-or fights
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive);
endmodule

`default_nettype wire

// [ebp_pkg.sv]
/*
 * Types shared by the eight-bit I/O port: controller states, register select
 * and the captured bus request. Assumes ebp_defs.svh is on the include path.
 */
`default_nettype none

`include "ebp_defs.svh"

package ebp_pkg;

    typedef enum logic {
        EBP_IDLE,
        EBP_ACK
    } ebp_state_e;

    typedef enum logic [2:0] {
        EBP_SEL_NONE,
        EBP_SEL_DATA,
        EBP_SEL_DIR,
        EBP_SEL_SET,
        EBP_SEL_CLEAR
    } ebp_sel_e;

    typedef struct packed {
        ebp_sel_e sel;
        logic we;
        logic be0;
        logic [`EBP_PORT_W-1:0] wdata;
    } ebp_req_s;

    localparam ebp_req_s EBP_REQ_IDLE = '{
        sel: EBP_SEL_NONE,
        we: 1'b0,
        be0: 1'b0,
        wdata: '0
    };

endpackage

`default_nettype wire
